// file: hw/srap_defs.vh
// Constants shared by the serial register access port design files
//
// What this block does
// - Answer addresses 4C to 4F from straps
// - Slave only, never starts a transfer
// - Data changes only while clock is low
// - Data change during clock high is condition
// - Both lines rest high when bus idle
// - First byte: seven address bits, direction
// - Acknowledge own address on ninth pulse
// - No acknowledge on mismatch or index 0F
// - Every byte shifted most significant first
// - Write refused leaves data line high
// - Master high in ack slot ends read
// - Write: address, pointer, then data bytes
// - Pointer advances after each written byte
// - Read: load pointer, readdress, send data
// - Pointer advances after each read byte
// - Repeated start accepted without stop
// - Pointer kept across stop and start
// - Power down keeps register contents
`ifndef SRAP_DEFS_VH
`define SRAP_DEFS_VH

// ----------------------------------------------------------------------
// Bus addressing
// ----------------------------------------------------------------------
`define SRAP_BASE_ADDR 7'h4C
`define SRAP_REFUSED_IDX 8'h0F

// ----------------------------------------------------------------------
// Byte framing
// ----------------------------------------------------------------------
`define SRAP_LAST_BIT 4'h7
`define SRAP_ACK_SLOT 4'h8
`define SRAP_PTR_STEP 8'h01
`define SRAP_AWAIT_FALL 4'hF

// ----------------------------------------------------------------------
// Register file
// ----------------------------------------------------------------------
`define SRAP_REG_COUNT 16
`define SRAP_REG_RESET 8'h00
`define SRAP_SYNC_WIDTH 5

`endif

// file: hw/srap_sync.v
// Two-stage synchroniser for pins entering the ref_clk domain
`timescale 1ns/100ps
`default_nettype none

module srap_sync #(
    parameter WIDTH = 1
)(
    // Clock and reset
    input wire clk,
    input wire reset,
    // Pin side and clock side
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta;

    // First stage feeds only the second stage, never any logic
    always @(posedge clk)
    begin
        if (reset)
        begin
            meta <= {WIDTH{1'b1}};
            sync_out <= {WIDTH{1'b1}};
        end
        else
        begin
            meta <= async_in;
            sync_out <= meta;
        end
    end

endmodule // srap_sync

`default_nettype wire

// file: hw/srap_port.v
// Two-wire serial slave port holding the device control registers
`timescale 1ns/100ps
`default_nettype none
`include "srap_defs.vh"

module srap_port #(
    parameter REG_COUNT = `SRAP_REG_COUNT
)(
    // Clock and reset
    input wire ref_clk,
    input wire reset,
    // Serial bus pins
    input wire scl_in,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe,
    // Straps and power control
    input wire [1:0] addr_select_pins,
    input wire low_power_request_n,
    output reg powered_down,
    // Register contents toward the device core
    output reg [REG_COUNT*8-1:0] reg_image,
    output reg wr_strobe,
    output reg [7:0] wr_index,
    output reg [7:0] wr_data,
    // Port status
    output reg [7:0] pointer,
    output reg bus_busy
);

    // ------------------------------------------------------------------
    // States of the byte engine
    // ------------------------------------------------------------------
    localparam [2:0] ST_IDLE = 3'b000;
    localparam [2:0] ST_ADDR = 3'b001;
    localparam [2:0] ST_PTR = 3'b010;
    localparam [2:0] ST_WDATA = 3'b011;
    localparam [2:0] ST_RDATA = 3'b100;
    localparam [2:0] ST_IGNORE = 3'b101;

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------

    // Indexes beyond the register file read as zero
    function [7:0] read_byte;
        input [REG_COUNT*8-1:0] image;
        input [7:0] idx;
        integer k;
        begin
            read_byte = `SRAP_REG_RESET;
            for (k = 0; k < REG_COUNT; k = k + 1)
            begin
                if (idx == k[7:0])
                begin
                    read_byte = image[k*8 +: 8];
                end
            end
        end
    endfunction

    // Only the reserved index is refused; indexes beyond the register
    // file are taken but store nothing and read as zero
    function is_refused;
        input [7:0] idx;
        begin
            is_refused = (idx == `SRAP_REFUSED_IDX);
        end
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisation and edge detection
    // ------------------------------------------------------------------
    wire [`SRAP_SYNC_WIDTH-1:0] sync_bus;
    wire scl_s;
    wire sda_s;
    wire [1:0] strap_s;
    wire pwr_n_s;
    reg scl_d;
    reg sda_d;

    srap_sync #(
        .WIDTH(`SRAP_SYNC_WIDTH)
    ) u_sync (
        .clk(ref_clk),
        .reset(reset),
        .async_in({scl_in, sda_in, addr_select_pins, low_power_request_n}),
        .sync_out(sync_bus)
    );

    assign scl_s = sync_bus[4];
    assign sda_s = sync_bus[3];
    assign strap_s = sync_bus[2:1];
    assign pwr_n_s = sync_bus[0];

    // Both pins pass one synchroniser, so they stay aligned in time
    // Data moving while the clock is high is a condition, not a bit
    wire start_seen = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_seen = scl_s & scl_d & ~sda_d & sda_s;
    wire scl_rise = scl_s & ~scl_d;
    wire scl_fall = ~scl_s & scl_d;

    // ------------------------------------------------------------------
    // Engine state
    // ------------------------------------------------------------------
    reg [2:0] state;
    reg [3:0] bit_cnt;
    reg [7:0] shift;
    reg [6:0] own_addr;
    reg acked;
    reg rw_read;
    reg master_nack;
    integer i;

    // Pointer arithmetic wraps at eight bits
    wire [7:0] next_pointer = pointer + `SRAP_PTR_STEP;
    wire [7:0] next_tx = read_byte(reg_image, next_pointer);
    wire [7:0] cur_tx = read_byte(reg_image, pointer);
    wire addr_match = (shift[7:1] == own_addr);
    wire receiving = (state == ST_ADDR) || (state == ST_PTR) ||
                     (state == ST_WDATA);

    // ------------------------------------------------------------------
    // Straps, power and idle status
    // ------------------------------------------------------------------

    // Strap is resampled every cycle so a late strap still takes effect
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            own_addr <= `SRAP_BASE_ADDR;
            powered_down <= 1'b0;
            bus_busy <= 1'b0;
            sda_out <= 1'b0;
        end
        else
        begin
            own_addr <= `SRAP_BASE_ADDR + {5'h00, strap_s};
            powered_down <= ~pwr_n_s;
            bus_busy <= (state != ST_IDLE);
            sda_out <= 1'b0; // Open drain: only ever pulls low
        end
    end

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------

    // Power down does not touch the contents, only reset and writes do
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            reg_image <= {REG_COUNT{`SRAP_REG_RESET}};
        end
        else if (wr_strobe)
        begin
            for (i = 0; i < REG_COUNT; i = i + 1)
            begin
                if (wr_index == i[7:0])
                begin
                    reg_image[i*8 +: 8] <= wr_data;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Byte engine
    // ------------------------------------------------------------------

    // Slave only: every action is paced by edges the master makes
    // No clock stretching, so the master must hold the clock low for at
    // least four ref_clk cycles to leave room for the data change
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            acked <= 1'b0;
            rw_read <= 1'b0;
            master_nack <= 1'b0;
            sda_oe <= 1'b0;
            pointer <= 8'h00;
            wr_strobe <= 1'b0;
            wr_index <= 8'h00;
            wr_data <= 8'h00;
        end
        else
        begin
            scl_d <= scl_s;
            sda_d <= sda_s;
            wr_strobe <= 1'b0;
            if (start_seen)
            begin
                // Plain or repeated start; pointer is left alone and any
                // partly shifted byte is dropped
                state <= ST_ADDR;
                // The master pulls the clock low once after every start;
                // that fall must not count as a bit
                bit_cnt <= `SRAP_AWAIT_FALL;
                sda_oe <= 1'b0;
            end
            else if (stop_seen)
            begin
                state <= ST_IDLE;
                bit_cnt <= 4'h0;
                sda_oe <= 1'b0;
            end
            else if (scl_rise)
            begin
                // Sample while the clock is high, data is stable then
                if (receiving && (bit_cnt < `SRAP_ACK_SLOT))
                begin
                    shift <= {shift[6:0], sda_s};
                end
                if ((state == ST_RDATA) && (bit_cnt == `SRAP_ACK_SLOT))
                begin
                    master_nack <= sda_s;
                end
            end
            else if (scl_fall && (state != ST_IDLE) &&
                     (state != ST_IGNORE))
            begin
                // All drive changes happen just after the clock falls
                if (bit_cnt == `SRAP_AWAIT_FALL)
                begin
                    // Fall that closes the start: no bit sent yet
                    bit_cnt <= 4'h0;
                end
                else if (bit_cnt == `SRAP_LAST_BIT)
                begin
                    bit_cnt <= `SRAP_ACK_SLOT;
                    case (state)
                        ST_ADDR:
                        begin
                            rw_read <= shift[0];
                            acked <= addr_match &&
                                !(shift[0] && is_refused(pointer));
                            sda_oe <= addr_match &&
                                !(shift[0] && is_refused(pointer));
                        end
                        ST_PTR:
                        begin
                            pointer <= shift;
                            acked <= !is_refused(shift);
                            sda_oe <= !is_refused(shift);
                        end
                        ST_WDATA:
                        begin
                            // A write aimed at the reserved index is lost
                            acked <= !is_refused(pointer);
                            sda_oe <= !is_refused(pointer);
                            if (!is_refused(pointer))
                            begin
                                wr_strobe <= 1'b1;
                                wr_index <= pointer;
                                wr_data <= shift;
                                pointer <= next_pointer;
                            end
                        end
                        ST_RDATA:
                        begin
                            // Let go so the master can answer
                            sda_oe <= 1'b0;
                        end
                        default:
                        begin
                            sda_oe <= 1'b0;
                        end
                    endcase
                end
                else if (bit_cnt == `SRAP_ACK_SLOT)
                begin
                    bit_cnt <= 4'h0;
                    sda_oe <= 1'b0;
                    case (state)
                        ST_ADDR:
                        begin
                            if (!acked)
                            begin
                                state <= ST_IGNORE;
                            end
                            else if (rw_read)
                            begin
                                state <= ST_RDATA;
                                shift <= cur_tx;
                                sda_oe <= ~cur_tx[7];
                            end
                            else
                            begin
                                state <= ST_PTR;
                            end
                        end
                        ST_PTR:
                        begin
                            // Refused pointer: line stays high, await stop
                            state <= acked ? ST_WDATA : ST_IGNORE;
                        end
                        ST_WDATA:
                        begin
                            state <= acked ? ST_WDATA : ST_IGNORE;
                        end
                        ST_RDATA:
                        begin
                            pointer <= next_pointer;
                            if (master_nack)
                            begin
                                state <= ST_IGNORE;
                            end
                            else
                            begin
                                shift <= next_tx;
                                sda_oe <= ~next_tx[7];
                            end
                        end
                        default:
                        begin
                            state <= ST_IGNORE;
                        end
                    endcase
                end
                else
                begin
                    bit_cnt <= bit_cnt + 4'h1;
                    if (state == ST_RDATA)
                    begin
                        // Next bit goes out while the clock is low
                        shift <= {shift[6:0], 1'b0};
                        sda_oe <= ~shift[6];
                    end
                end
            end
        end
    end

endmodule // srap_port

`default_nettype wire

// file: tb/srap_host.sv
// Two-wire bus master model that drives the port from the host side
`timescale 1ns/100ps
`default_nettype none

module srap_host (
    // Clock and bus lines
    input wire logic ref_clk,
    input wire logic sda_in,
    output var logic scl,
    output var logic sda_low
);
    // Idle bus rests high; the clock stands still outside frames
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // One bit; data moves mid low phase, sampled late in the high phase
    task automatic bit_io(input logic v, output logic s);
        tick(2);
        sda_low = !v;
        tick(2);
        scl = 1'b1;
        tick(4);
        s = sda_in;
        scl = 1'b0;
    endtask

    // Start, or a repeated start when the clock is already low
    task automatic start();
        if (!scl)
        begin
            tick(2);
            sda_low = 1'b0;
            tick(2);
            scl = 1'b1;
            tick(4);
        end
        sda_low = 1'b1;
        tick(4);
        scl = 1'b0;
    endtask

    task automatic stop();
        tick(2);
        sda_low = 1'b1;
        tick(2);
        scl = 1'b1;
        tick(4);
        sda_low = 1'b0;
        tick(8);
    endtask

    // Byte out, top bit first, then the acknowledge slot released
    task automatic put(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], s);
        bit_io(1'b1, s);
        ack = !s;
    endtask

    // Byte in; a high acknowledge marks the last byte
    task automatic get(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(1'b1, s);
            b[i] = s;
        end
        bit_io(last, s);
    endtask
endmodule // srap_host

`default_nettype wire

// file: tb/srap_port_asserts.sv
// Assertions on the pins of the serial register access port
`timescale 1ns/100ps
`default_nettype none

module srap_port_asserts #(
    parameter REG_COUNT = 16
)(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Watched pins and status
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic low_power_request_n,
    input wire logic powered_down,
    input wire logic [REG_COUNT*8-1:0] reg_image,
    input wire logic wr_strobe,
    input wire logic [7:0] wr_index,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] pointer,
    input wire logic bus_busy
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    // ----------------------------------------------------------------
    // Bus conditions and port behaviour
    // ----------------------------------------------------------------
    // Conditions need the clock high on two samples, so the device's
    // own late data changes never look like one
    sequence s_start;
        scl_in && $past(scl_in) && $fell(sda_in);
    endsequence
    sequence s_stop;
        scl_in && $past(scl_in) && $rose(sda_in);
    endsequence

    a_open_drain: assert property (!sda_out)
        else $error("data pin driven high");
    a_idle_quiet: assert property (!bus_busy |-> !sda_oe)
        else $error("data pin pulled while idle");
    a_change_low: assert property ($changed(sda_oe) |->
        !$past(scl_in, 2) || !$past(scl_in, 3) || !$past(scl_in, 4))
        else $error("data changed in clock high phase");
    a_start_busy: assert property (s_start |-> ##[1:6] bus_busy)
        else $error("start not taken");
    a_stop_idle: assert property (s_stop |-> ##[1:8] !bus_busy)
        else $error("stop not taken");
    a_drive_stands: assert property ($rose(sda_oe) |-> sda_oe [*6])
        else $error("pull low too short");
    a_write_step: assert property (wr_strobe |->
        sda_oe && pointer == wr_index + 8'h01)
        else $error("write without ack or step");
    a_store_byte: assert property (wr_strobe && wr_index < REG_COUNT
        |=> reg_image[wr_index*8 +: 8] == wr_data)
        else $error("written byte not stored");
    a_image_hold: assert property ($changed(reg_image) |->
        $past(wr_strobe))
        else $error("registers changed without a write");
    a_power_seen: assert property ($fell(low_power_request_n) |->
        ##[1:4] powered_down)
        else $error("power down not seen");
endmodule // srap_port_asserts

bind srap_port srap_port_asserts #(.REG_COUNT(REG_COUNT)) u_chk (
    .ref_clk(ref_clk), .reset(reset), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe),
    .low_power_request_n(low_power_request_n),
    .powered_down(powered_down), .reg_image(reg_image),
    .wr_strobe(wr_strobe), .wr_index(wr_index), .wr_data(wr_data),
    .pointer(pointer), .bus_busy(bus_busy)
);

`default_nettype wire

// file: tb/test_serial_register_access_port.sv
// Self-checking bench for the serial register access port
`timescale 1ns/100ps
`default_nettype none

module test_serial_register_access_port;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [1:0] straps = 2'h0;
    logic lp_n = 1'b1;
    logic scl, host_low, sda_out, sda_oe, pd, wr_strobe, busy;
    logic [127:0] image;
    logic [7:0] wr_index, wr_data, ptr, d;
    logic [6:0] dev = 7'h4F;
    logic [7:0] mem [16] = '{default: 8'h00};
    int bad_count = 0;
    int n_compared = 0;
    // Open-drain line with pull-up
    wire logic sda_line = !((sda_oe && !sda_out) || host_low);

    always #25 ref_clk = ~ref_clk;

    srap_host host (.ref_clk(ref_clk), .sda_in(sda_line), .scl(scl),
        .sda_low(host_low));
    srap_port #(.REG_COUNT(16)) dut (.ref_clk(ref_clk), .reset(reset),
        .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe(sda_oe), .addr_select_pins(straps),
        .low_power_request_n(lp_n), .powered_down(pd),
        .reg_image(image), .wr_strobe(wr_strobe), .wr_index(wr_index),
        .wr_data(wr_data), .pointer(ptr), .bus_busy(busy));

    // ----------------------------------------------------------------
    // Compare and helper tasks
    // ----------------------------------------------------------------
    task automatic cmp(input string w, input logic [7:0] e,
        input logic [7:0] g);
        n_compared++;
        if (g !== e)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic cmp_bit(input string w, input logic e, input logic g);
        n_compared++;
        if (g !== e)
        begin
            bad_count++;
            $display("BAD %s expected %b seen %b", w, e, g);
        end
    endtask
    task automatic send(input logic [7:0] b, input logic e, input string w);
        logic a;
        host.put(b, a);
        cmp_bit(w, e, a);
    endtask
    task automatic chk_regs();
        for (int i = 0; i < 16; i++)
            cmp("register", mem[i], image[i*8 +: 8]);
    endtask
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Every strap value; a foreign address is ignored until a new start
    task automatic t_straps();
        for (int s = 0; s < 4; s++)
        begin
            straps = 2'(s);
            host.tick(6);
            host.start();
            send({7'h4C + 7'(s), 1'b0}, 1'b1, "own address");
            host.start();
            send({7'h4C + 7'((s + 1) % 4), 1'b0}, 1'b0, "other");
            send(8'h00, 1'b0, "ignored byte");
            host.stop();
        end
    endtask

    // Burst write of four bytes from register 3
    task automatic t_write();
        logic [7:0] v [4] = '{8'hA5, 8'h3C, 8'h81, 8'h7E};
        host.start();
        send({dev, 1'b0}, 1'b1, "write address");
        send(8'h03, 1'b1, "pointer");
        for (int i = 0; i < 4; i++)
        begin
            send(v[i], 1'b1, "data");
            mem[3 + i] = v[i];
        end
        host.stop();
        chk_regs();
        cmp("pointer", 8'h07, ptr);
    endtask

    // Pointer set, stop, burst read; then a read after a repeated start
    task automatic t_read();
        host.start();
        send({dev, 1'b0}, 1'b1, "write address");
        send(8'h03, 1'b1, "pointer");
        host.stop();
        host.start();
        send({dev, 1'b1}, 1'b1, "read address");
        for (int i = 0; i < 4; i++)
        begin
            host.get(i == 3, d);
            cmp("read data", mem[3 + i], d);
        end
        host.stop();
        cmp("pointer", 8'h07, ptr);
        host.start();
        send({dev, 1'b0}, 1'b1, "write address");
        send(8'h05, 1'b1, "pointer");
        host.start();
        send({dev, 1'b1}, 1'b1, "read address");
        host.get(1'b1, d);
        cmp("read data", mem[5], d);
        host.stop();
    endtask

    // Index 0F refused as pointer, as write target and as read source
    task automatic t_refused();
        host.start();
        send({dev, 1'b0}, 1'b1, "write address");
        send(8'h0E, 1'b1, "pointer");
        send(8'hC3, 1'b1, "data");
        mem[14] = 8'hC3;
        send(8'h99, 1'b0, "data at 0F");
        host.stop();
        host.start();
        send({dev, 1'b1}, 1'b0, "read at 0F");
        host.stop();
        host.start();
        send({dev, 1'b0}, 1'b1, "write address");
        send(8'h0F, 1'b0, "pointer 0F");
        host.stop();
        chk_regs();
    endtask

    // Power down keeps every register
    task automatic t_power();
        lp_n = 1'b0;
        host.tick(5);
        cmp_bit("powered down", 1'b1, pd);
        chk_regs();
        lp_n = 1'b1;
        host.tick(5);
        cmp_bit("powered down", 1'b0, pd);
        chk_regs();
    endtask

    // Main sequence; inputs change on falling edges only
    initial
    begin
        repeat (20) @(negedge ref_clk);
        reset = 1'b0;
        host.tick(6);
        t_straps();
        t_write();
        t_read();
        t_refused();
        t_power();
        stop_test();
    end

    // Hang guard
    initial
    begin
        repeat (100000) @(posedge ref_clk);
        bad_count++;
        stop_test();
    end
endmodule // test_serial_register_access_port

`default_nettype wire
